// file: verilog/i2c_status_map.vh
// Register offsets, field positions and reset values of the bus status flag logic
`ifndef I2C_STATUS_MAP_VH
`define I2C_STATUS_MAP_VH

// Register offsets
`define TRANSMIT_BYTE_OFS      8'h06
`define RECEIVE_BYTE_OFS       8'h06
`define BUS_STATUS_PRIMARY_OFS 8'h07
`define BUS_STATUS_ERRORS_OFS  8'h08

// Reset values
`define TRANSMIT_BYTE_RST      8'h00
`define STATUS_RST             8'h00

// Primary status fields
`define EVENT_SUMMARY_BIT      7
`define TEN_BIT_HEADER_BIT     6
`define TRANSFER_DIR_BIT       5
`define BUS_BUSY_BIT           4
`define BYTE_DONE_BIT          3
`define ADDRESS_MATCHED_BIT    2
`define MASTER_MODE_BIT        1
`define START_SENT_BIT         0

// Error status fields
`define ACK_FAILURE_BIT        4
`define STOP_SEEN_BIT          3
`define ARBITRATION_LOST_BIT   2
`define BUS_ERROR_BIT          1
`define GENERAL_CALL_BIT       0

// General call address
`define GENERAL_CALL_ADDR      7'h00

`endif

// file: verilog/i2c_status_flag_logic.v
// Status registers, event flags, clock stretch and transmit byte of a two-wire bus interface
`timescale 1ns/100ps
`include "i2c_status_map.vh"

// Operation
// - Summary event flag follows any event; cleared by the sequences or error status read.
// - Ten-bit header flag set after first address byte; cleared by error read then write.
// - Direction flag shows transmit or receive; cleared with byte-done, stop, arbitration, disable.
// - Bus-busy set on Start, cleared on Stop, tracked even when disabled.
// - Byte-done set per byte; cleared by primary read then data read or write.
// - Transmit byte-done waits for acknowledge clock; address byte waits for address-done.
// - Receive byte-done set after acknowledge clock driven, only with acknowledge enabled.
// - Clock line held low while byte-done or address-matched is set.
// - Address-matched on own address or general call; cleared by primary read or disable.
// - Master flag set on start request; cleared by Stop, arbitration loss or disable.
// - Start-sent set after Start; cleared by primary read then address write.
// - Acknowledge failure on unacknowledged transmit; cleared by error read or disable.
// - Stop-seen in slave mode after acknowledged byte; cleared by error read or disable.
// - Arbitration-lost set, returns to slave; cleared by error read or disable.
// - Bus error on misplaced Start or Stop; cleared by error read or disable.
// - General-call-seen when enabled; cleared by Stop or disable.
// - Clock line released while any error flag is set.
// - Writing the transmit byte starts its transmission.
// - One interrupt, gated by interrupt enable and interface mask.
module i2c_status_flag_logic (
	// Clock and reset
	input  wire       clk_sys,
	input  wire       reset_n,
	// Register port
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_write,
	input  wire       reg_read,
	output reg  [7:0] reg_rdata,
	// Control bits
	input  wire       peripheral_enable,
	input  wire       interrupt_enable,
	input  wire       general_call_enable,
	input  wire       ack_enable,
	input  wire       start_request,
	input  wire       interface_irq_mask,
	input  wire [7:0] own_address,
	// Bit engine events, one-cycle pulses; received address, byte-in-progress level and received byte
	input  wire       tx_ack_clock_seen,
	input  wire       rx_ack_clock_driven,
	input  wire       address_done_event,
	input  wire       ten_bit_header_done,
	input  wire       start_generated,
	input  wire       tx_not_acknowledged,
	input  wire       arbitration_lost_event,
	input  wire       rx_address_valid,
	input  wire [7:0] rx_address,
	input  wire       byte_in_progress,
	input  wire [7:0] received_byte,
	// Bus pins
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        scl_out,
	output reg        scl_oe,
	// Transmit path
	output reg  [7:0] transmit_byte,
	output reg        transmit_load,
	// Interrupt
	output reg        irq
);

	////////////////////////////////////////////////////////////////////////////////
	// Flag update: set wins over clear
	function flag_next;
		input cur;
		input set;
		input clr;
		begin
			flag_next = set | (cur & ~clr);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection
	reg  [1:0] scl_sync;
	reg  [1:0] sda_sync;
	reg        scl_prev;
	reg        sda_prev;
	wire       scl_s = scl_sync[1];
	wire       sda_s = sda_sync[1];
	wire       start_det = scl_s & scl_prev & sda_prev & ~sda_s;
	wire       stop_det  = scl_s & scl_prev & ~sda_prev & sda_s;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_in};
			sda_sync <= {sda_sync[0], sda_in};
			scl_prev <= scl_s;
			sda_prev <= sda_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags
	reg  event_summary;
	reg  ten_bit_header_sent;
	reg  transfer_direction;
	reg  bus_busy;
	reg  byte_done;
	reg  address_matched;
	reg  master_mode_flag;
	reg  start_sent;
	reg  ack_failure;
	reg  stop_seen;
	reg  arbitration_lost;
	reg  bus_error_flag;
	reg  general_call_seen;
	reg  address_sent;
	reg  acked_since_start;
	reg  primary_read_armed;
	reg  errors_read_armed;
	reg  start_request_prev;

	// Register accesses
	wire pe        = peripheral_enable;
	wire rd_prim   = reg_read & (reg_addr == `BUS_STATUS_PRIMARY_OFS);
	wire rd_err    = reg_read & (reg_addr == `BUS_STATUS_ERRORS_OFS);
	wire rd_data   = reg_read & (reg_addr == `RECEIVE_BYTE_OFS);
	wire wr_data   = reg_write & (reg_addr == `TRANSMIT_BYTE_OFS);

	// Event sources
	wire gc_hit    = general_call_enable & (rx_address[7:1] == `GENERAL_CALL_ADDR);
	wire own_hit   = (rx_address[7:1] == own_address[7:1]) & (rx_address[7:1] != 7'h00);
	wire set_match = pe & ~master_mode_flag & rx_address_valid & (own_hit | gc_hit);
	wire set_tx    = pe & (tx_ack_clock_seen | address_done_event);
	wire set_rx    = pe & rx_ack_clock_driven & ack_enable;
	wire set_btf   = set_tx | set_rx;
	wire set_sb    = pe & start_generated;
	wire set_h10   = pe & ten_bit_header_done;
	wire set_af    = pe & tx_not_acknowledged;
	wire set_stop  = pe & stop_det & ~master_mode_flag & acked_since_start;
	wire set_arbitration_lost  = pe & arbitration_lost_event;
	wire set_bus_error_flag  = pe & (start_det | stop_det) & byte_in_progress;
	wire set_general_call_seen  = set_match & gc_hit;
	wire set_ms    = pe & start_request & ~start_request_prev;

	// Two-step clears
	wire clr_btf   = primary_read_armed & (rd_data | wr_data);
	wire clr_sb    = primary_read_armed & wr_data;
	wire clr_h10   = errors_read_armed & wr_data;
	wire err_any   = ack_failure | stop_seen | arbitration_lost | bus_error_flag;

	// Next values
	wire next_byte_done  = pe & flag_next(byte_done, set_btf, clr_btf);
	wire next_match      = pe & flag_next(address_matched, set_match, rd_prim);
	wire next_start_sent = pe & flag_next(start_sent, set_sb, clr_sb);
	wire next_h10        = pe & flag_next(ten_bit_header_sent, set_h10, clr_h10);
	wire next_af         = pe & flag_next(ack_failure, set_af, rd_err);
	wire next_stop       = pe & flag_next(stop_seen, set_stop, rd_err);
	wire next_arbitration_lost       = pe & flag_next(arbitration_lost, set_arbitration_lost, rd_err);
	wire next_bus_error_flag       = pe & flag_next(bus_error_flag, set_bus_error_flag, rd_err);
	wire next_addr_sent  = pe & flag_next(address_sent, pe & address_done_event, rd_prim);
	wire next_summary    = next_byte_done | next_match | next_start_sent | next_h10 |
	                       next_af | next_stop | next_arbitration_lost | next_bus_error_flag | next_addr_sent;
	wire next_scl_hold   = (next_byte_done | next_match) &
	                       ~(next_af | next_stop | next_arbitration_lost | next_bus_error_flag);

	// Start request edge detector
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			start_request_prev <= 1'b0;
		end else begin
			start_request_prev <= start_request;
		end
	end

	// Byte done
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			byte_done <= 1'b0;
		end else begin
			byte_done <= next_byte_done;
		end
	end

	// Address matched
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			address_matched <= 1'b0;
		end else begin
			address_matched <= next_match;
		end
	end

	// Start sent
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			start_sent <= 1'b0;
		end else begin
			start_sent <= next_start_sent;
		end
	end

	// Ten-bit header sent
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ten_bit_header_sent <= 1'b0;
		end else begin
			ten_bit_header_sent <= next_h10;
		end
	end

	// Acknowledge failure
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ack_failure <= 1'b0;
		end else begin
			ack_failure <= next_af;
		end
	end

	// Stop seen
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			stop_seen <= 1'b0;
		end else begin
			stop_seen <= next_stop;
		end
	end

	// Arbitration lost
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			arbitration_lost <= 1'b0;
		end else begin
			arbitration_lost <= next_arbitration_lost;
		end
	end

	// Bus error
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bus_error_flag <= 1'b0;
		end else begin
			bus_error_flag <= next_bus_error_flag;
		end
	end

	// Address sent as master, only feeds the summary
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			address_sent <= 1'b0;
		end else begin
			address_sent <= next_addr_sent;
		end
	end

	// Summary event flag
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			event_summary <= 1'b0;
		end else begin
			event_summary <= next_summary;
		end
	end

	// Busy tracks the bus regardless of enable
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			bus_busy <= 1'b0;
		end else begin
			if (start_det) begin
				bus_busy <= 1'b1;
			end else if (stop_det) begin
				bus_busy <= 1'b0;
			end
		end
	end

	// Direction valid only with byte done
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			transfer_direction <= 1'b0;
		end else begin
			if (!pe || stop_det || set_arbitration_lost) begin
				transfer_direction <= 1'b0;
			end else if (set_btf) begin
				transfer_direction <= set_tx;
			end else if (clr_btf) begin
				transfer_direction <= 1'b0;
			end
		end
	end

	// Master mode, arbitration loss drops back to slave
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			master_mode_flag <= 1'b0;
		end else begin
			if (!pe || stop_det || set_arbitration_lost) begin
				master_mode_flag <= 1'b0;
			end else if (set_ms) begin
				master_mode_flag <= 1'b1;
			end
		end
	end

	// General call seen
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			general_call_seen <= 1'b0;
		end else begin
			general_call_seen <= pe & flag_next(general_call_seen, set_general_call_seen, stop_det);
		end
	end

	// Acknowledged traffic since the last Start, qualifies stop-seen
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			acked_since_start <= 1'b0;
		end else begin
			acked_since_start <= pe & flag_next(acked_since_start, set_rx | set_match,
			                                    stop_det | start_det);
		end
	end

	// Arm second steps of clearing sequences
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			primary_read_armed <= 1'b0;
		end else begin
			if (!pe || clr_btf || clr_sb) begin
				primary_read_armed <= rd_prim;
			end else if (rd_prim) begin
				primary_read_armed <= 1'b1;
			end
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			errors_read_armed <= 1'b0;
		end else begin
			if (!pe || clr_h10) begin
				errors_read_armed <= rd_err;
			end else if (rd_err) begin
				errors_read_armed <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register read, transmit byte, clock line and interrupt
	reg [7:0] next_rdata;

	always @* begin
		next_rdata = 8'h00;
		if (reg_read) begin
			case (reg_addr)
				`RECEIVE_BYTE_OFS: begin
					next_rdata = received_byte;
				end
				`BUS_STATUS_PRIMARY_OFS: begin
					next_rdata[`EVENT_SUMMARY_BIT]   = event_summary;
					next_rdata[`TEN_BIT_HEADER_BIT]  = ten_bit_header_sent;
					next_rdata[`TRANSFER_DIR_BIT]    = transfer_direction;
					next_rdata[`BUS_BUSY_BIT]        = bus_busy;
					next_rdata[`BYTE_DONE_BIT]       = byte_done;
					next_rdata[`ADDRESS_MATCHED_BIT] = address_matched;
					next_rdata[`MASTER_MODE_BIT]     = master_mode_flag;
					next_rdata[`START_SENT_BIT]      = start_sent;
				end
				`BUS_STATUS_ERRORS_OFS: begin
					next_rdata[`ACK_FAILURE_BIT]      = ack_failure;
					next_rdata[`STOP_SEEN_BIT]        = stop_seen;
					next_rdata[`ARBITRATION_LOST_BIT] = arbitration_lost;
					next_rdata[`BUS_ERROR_BIT]        = bus_error_flag;
					next_rdata[`GENERAL_CALL_BIT]     = general_call_seen;
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata     <= `STATUS_RST;
			transmit_byte <= `TRANSMIT_BYTE_RST;
			transmit_load <= 1'b0;
			scl_out       <= 1'b0;
			scl_oe        <= 1'b0;
			irq           <= 1'b0;
		end else begin
			reg_rdata     <= next_rdata;
			transmit_load <= wr_data;
			if (wr_data)
				transmit_byte <= reg_wdata;
			scl_out <= 1'b0;
			scl_oe  <= next_scl_hold;
			irq     <= next_summary & interrupt_enable & interface_irq_mask;
		end
	end

endmodule // i2c_status_flag_logic

// file: testbench/i2c_status_flag_logic_chk.sv
// Port-level checker of the bus status flag logic
`timescale 1ns/100ps
module i2c_status_flag_logic_chk (
	// Clock and reset
	input wire       clk_sys,
	input wire       reset_n,
	// Register port
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_write,
	input wire       reg_read,
	input wire [7:0] reg_rdata,
	// Control and events
	input wire       peripheral_enable,
	input wire       interrupt_enable,
	input wire       interface_irq_mask,
	input wire       ack_enable,
	input wire       tx_ack_clock_seen,
	input wire       rx_ack_clock_driven,
	input wire       address_done_event,
	input wire       rx_address_valid,
	input wire       tx_not_acknowledged,
	input wire [7:0] received_byte,
	// Outputs
	input wire       scl_out,
	input wire       scl_oe,
	input wire [7:0] transmit_byte,
	input wire       transmit_load,
	input wire       irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire any_set = tx_ack_clock_seen | rx_ack_clock_driven | address_done_event | rx_address_valid;
	property p_load; reg_write && reg_addr == 8'h06 |=> transmit_load && transmit_byte == $past(reg_wdata); endproperty
	a_load: assert property (p_load) else $error("transmit byte not loaded");
	property p_load_src; transmit_load |-> $past(reg_write) && $past(reg_addr) == 8'h06; endproperty
	a_load_src: assert property (p_load_src) else $error("stray transmit load");
	property p_idle; !reg_read |=> reg_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	property p_unmapped; reg_read && (reg_addr < 8'h06 || reg_addr > 8'h08) |=> reg_rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rx_read; reg_read && reg_addr == 8'h06 |=> reg_rdata == $past(received_byte); endproperty
	a_rx_read: assert property (p_rx_read) else $error("received byte read wrong");
	property p_irq; irq |-> $past(interrupt_enable) && $past(interface_irq_mask); endproperty
	a_irq: assert property (p_irq) else $error("interrupt not gated");
	property p_tx; tx_ack_clock_seen && peripheral_enable |=> scl_oe; endproperty
	a_tx: assert property (p_tx) else $error("no stretch after transmit");
	property p_rx; rx_ack_clock_driven && ack_enable && peripheral_enable |=> scl_oe; endproperty
	a_rx: assert property (p_rx) else $error("no stretch after receive");
	property p_hold; scl_oe && !reg_read && !reg_write && peripheral_enable |=> scl_oe; endproperty
	a_hold: assert property (p_hold) else $error("stretch dropped early");
	property p_err; tx_not_acknowledged && !scl_oe && !any_set |=> !scl_oe; endproperty
	a_err: assert property (p_err) else $error("stretch on error");
	property p_off; !peripheral_enable |=> !scl_oe ##1 !scl_out; endproperty
	a_off: assert property (p_off) else $error("stretch while disabled");
	c_load: cover property (transmit_load);
	c_stretch: cover property (scl_oe ##1 !scl_oe);
	c_irq: cover property ($rose(irq));
endmodule // i2c_status_flag_logic_chk
bind i2c_status_flag_logic i2c_status_flag_logic_chk chk (.clk_sys, .reset_n, .reg_addr, .reg_wdata,
	.reg_write, .reg_read, .reg_rdata, .peripheral_enable, .interrupt_enable, .interface_irq_mask,
	.ack_enable, .tx_ack_clock_seen, .rx_ack_clock_driven, .address_done_event, .rx_address_valid,
	.tx_not_acknowledged, .received_byte, .scl_out, .scl_oe, .transmit_byte, .transmit_load, .irq);

// file: testbench/bus_peer.sv
// Other bus party: drives Start and Stop on the pulled-up lines
`timescale 1ns/100ps
module bus_peer (
	// Bus lines, high when released
	output reg scl_bus,
	output reg sda_bus
);
	initial begin
		scl_bus = 1'b1;
		sda_bus = 1'b1;
	end
	task start_cond; begin #160 sda_bus = 1'b0; #160 scl_bus = 1'b0; end endtask
	task stop_cond; begin sda_bus = 1'b0; #160 scl_bus = 1'b1; #160 sda_bus = 1'b1; end endtask
endmodule // bus_peer

// file: testbench/i2c_status_flag_logic_tb_top.sv
// Testbench of the bus status flag logic
`timescale 1ns/100ps
module i2c_status_flag_logic_tb_top;
	reg        clk_sys, reset_n, reg_write, reg_read, peripheral_enable, interrupt_enable;
	reg        general_call_enable, ack_enable, start_request, interface_irq_mask, byte_in_progress;
	reg  [7:0] reg_addr, reg_wdata, own_address, rx_address, received_byte, ev;
	wire [7:0] reg_rdata, transmit_byte;
	wire       scl_out, scl_oe, transmit_load, irq, scl_bus, sda_bus;
	integer    err_total, compares;
	bus_peer peer (.scl_bus, .sda_bus);
	i2c_status_flag_logic dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .peripheral_enable, .interrupt_enable, .general_call_enable, .ack_enable,
		.start_request, .interface_irq_mask, .own_address, .tx_ack_clock_seen(ev[0]),
		.rx_ack_clock_driven(ev[1]), .address_done_event(ev[2]), .ten_bit_header_done(ev[3]),
		.start_generated(ev[4]), .tx_not_acknowledged(ev[5]), .arbitration_lost_event(ev[6]),
		.rx_address_valid(ev[7]), .rx_address, .byte_in_progress, .received_byte,
		.scl_in(scl_bus & ~scl_oe), .sda_in(sda_bus), .scl_out, .scl_oe, .transmit_byte,
		.transmit_load, .irq);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task chk(input [8*6:1] nm, input [7:0] seen, input [7:0] exp); begin
		compares = compares + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("[ERR] %0s expected %h seen %h", nm, exp, seen);
		end
	end endtask
	task wr(input [7:0] a, input [7:0] v); begin
		@(posedge clk_sys); reg_addr <= a; reg_wdata <= v; reg_write <= 1'b1;
		@(posedge clk_sys); reg_write <= 1'b0; #1;
	end endtask
	task rd(input [7:0] a, input [7:0] m, input [7:0] e); begin
		@(posedge clk_sys); reg_addr <= a; reg_read <= 1'b1;
		@(posedge clk_sys); reg_read <= 1'b0; #1;
		chk("rdata", reg_rdata & m, e);
	end endtask
	task pulse(input integer n); begin
		@(posedge clk_sys); ev[n] <= 1'b1;
		@(posedge clk_sys); ev <= 8'h00; #1;
	end endtask
	task print_verdict; begin
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	end endtask
	initial begin
		#3000000; err_total = err_total + 1; print_verdict;
	end
	initial begin
		{reg_write, reg_read, peripheral_enable, interrupt_enable, general_call_enable} = 5'h00;
		{ack_enable, start_request, interface_irq_mask, byte_in_progress, reset_n} = 5'h00;
		{reg_addr, reg_wdata, rx_address, received_byte, ev} = 40'h00;
		own_address = 8'h5A; compares = 0; err_total = 0;
		repeat (8) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(8'h07, 8'hFF, 8'h00); rd(8'h08, 8'hFF, 8'h00); rd(8'h20, 8'hFF, 8'h00);
		{peripheral_enable, interrupt_enable, interface_irq_mask} <= 3'h7;
		{ack_enable, general_call_enable, start_request} <= 3'h7;
		rd(8'h07, 8'h02, 8'h02);
		pulse(4); chk("irq", irq, 8'h01);
		rd(8'h07, 8'h81, 8'h81);
		wr(8'h06, 8'hA5); chk("load", transmit_load, 8'h01);
		chk("txbyte", transmit_byte, 8'hA5); rd(8'h07, 8'h01, 8'h00);
		pulse(2); chk("scl_oe", scl_oe, 8'h01); rd(8'h07, 8'h88, 8'h88);
		wr(8'h06, 8'h3C); rd(8'h07, 8'h08, 8'h00); chk("scl_oe", scl_oe, 8'h00);
		pulse(0); rd(8'h07, 8'h28, 8'h28); wr(8'h06, 8'hC3); rd(8'h07, 8'h28, 8'h00);
		pulse(5); chk("scl_oe", scl_oe, 8'h00);
		rd(8'h08, 8'h10, 8'h10); rd(8'h08, 8'h10, 8'h00);
		pulse(6); rd(8'h07, 8'h02, 8'h00); rd(8'h08, 8'h04, 8'h04);
		start_request <= 1'b0;
		pulse(3); rd(8'h07, 8'h40, 8'h40); rd(8'h08, 8'h04, 8'h00);
		wr(8'h06, 8'h00); rd(8'h07, 8'h40, 8'h00);
		rx_address <= 8'h5B; pulse(7); chk("scl_oe", scl_oe, 8'h01);
		rd(8'h07, 8'h04, 8'h04); rd(8'h07, 8'h04, 8'h00); chk("scl_oe", scl_oe, 8'h00);
		rx_address <= 8'h00; pulse(7); rd(8'h08, 8'h01, 8'h01); rd(8'h07, 8'h04, 8'h04);
		ack_enable <= 1'b0; pulse(1); rd(8'h07, 8'h08, 8'h00);
		ack_enable <= 1'b1; received_byte <= 8'h3C; pulse(1); rd(8'h07, 8'h28, 8'h08);
		rd(8'h06, 8'hFF, 8'h3C); rd(8'h07, 8'h08, 8'h00);
		peripheral_enable <= 1'b0; peer.start_cond; repeat (4) @(posedge clk_sys);
		rd(8'h07, 8'hFF, 8'h10); peer.stop_cond; repeat (4) @(posedge clk_sys);
		rd(8'h07, 8'hFF, 8'h00);
		{peripheral_enable, byte_in_progress, interface_irq_mask} <= 3'h6;
		peer.start_cond; repeat (4) @(posedge clk_sys); chk("irq", irq, 8'h00);
		interface_irq_mask <= 1'b1; repeat (2) @(posedge clk_sys); chk("irq", irq, 8'h01);
		byte_in_progress <= 1'b0; rd(8'h08, 8'h02, 8'h02);
		peer.stop_cond; repeat (4) @(posedge clk_sys);
		peer.start_cond; repeat (4) @(posedge clk_sys);
		rx_address <= 8'h5A; pulse(7); rd(8'h07, 8'h04, 8'h04);
		peer.stop_cond; repeat (4) @(posedge clk_sys);
		rd(8'h08, 8'h08, 8'h08); rd(8'h08, 8'h08, 8'h00);
		print_verdict;
	end
endmodule // i2c_status_flag_logic_tb_top
